/* File: rtl/light_level_readout.sv */
// Purpose: light result registers and dark-level hysteresis comparator
// Assumes: register port already decoded from the two-wire serial link
// Notes:   results latch from the converter only on the refresh tick
//          the converter word's valid flag is ignored, the tick and the sensor enable decide
//          threshold plus hysteresis is summed in nine bits, so it cannot wrap
//          reads have no side effect, so a host may poll any byte freely
`timescale 1ns/10ps
module light_level_readout #(
   parameter int unsigned REFRESH_PERIOD = 32'(light_readout_pkg::REFRESH_CYCLES)
) (
   input  wire logic                                  clk_sys_i,
   input  wire logic                                  rst_n_i,

   // register port, already decoded from the serial link
   input  wire logic                                  reg_wr_i,
   input  wire logic                                  reg_rd_i,
   input  wire logic [light_readout_pkg::ADDR_W-1:0]  reg_addr_i,
   input  wire logic [light_readout_pkg::DATA_W-1:0]  reg_wdata_i,
   output logic      [light_readout_pkg::DATA_W-1:0]  reg_rdata_o,

   // converter words and per-sensor enables
   input  wire logic [1:0]                            sensor_en_i,
   input  wire light_readout_pkg::conversion_t        sensor_one_conv_i,
   input  wire light_readout_pkg::conversion_t        sensor_two_conv_i,

   // comparator inputs and backlight decision
   input  wire logic [7:0]                            sensor_level_i,
   input  wire logic [7:0]                            dark_entry_threshold_i,
   input  wire logic                                  dark_cmp_en_i,
   input  wire logic                                  office_cmp_en_i,
   input  wire logic                                  office_request_i,
   output light_readout_pkg::backlight_level_t        backlight_level_o,
   output logic                                       dark_trip_o
);
   // timing at a glance, in clock edges after the strobe or tick:
   //   write strobe at edge n  -> hysteresis holds the new code from n
   //   read strobe at edge n   -> reg_rdata_o shows the byte after n
   //   refresh tick at edge n  -> enabled results change after n
   //   input crosses at edge n -> dark_trip_o and level move after n+1
   // results reset to zero and stay there until the first tick, which
   // comes one full refresh period after reset is released
   // a full-scale period is long, so benches shorten REFRESH_PERIOD

   // register state
   logic [7:0]                                  dark_exit_hysteresis_ff;
   logic [light_readout_pkg::RESULT_W-1:0]      result_ff [light_readout_pkg::NUM_SENSORS];
   // converter side and refresh
   logic [light_readout_pkg::RESULT_W-1:0]      conv_value [light_readout_pkg::NUM_SENSORS];
   logic                                        refresh_tick;
   logic [light_readout_pkg::NUM_SENSORS-1:0]   capture_en;
   // byte views of each held result
   logic [light_readout_pkg::DATA_W-1:0]        level_low [light_readout_pkg::NUM_SENSORS];
   logic [light_readout_pkg::DATA_W-1:0]        level_high [light_readout_pkg::NUM_SENSORS];
   // register port decode
   logic                                        hys_wr_hit;
   logic [light_readout_pkg::DATA_W-1:0]        nxt_rdata;
   // comparator
   logic                                        dark_ff;
   logic [8:0]                                  exit_level;
   logic                                        above_exit;
   logic                                        below_entry;
   light_readout_pkg::backlight_level_t         nxt_level;

   // converter words unpacked into an indexable array
   assign conv_value[0] = sensor_one_conv_i.value;
   assign conv_value[1] = sensor_two_conv_i.value;

   // one divider serves both sensors, so their refreshes stay in step;
   // a sensor enabled mid-period waits for the shared tick
   refresh_tick #(
      .PERIOD    (REFRESH_PERIOD)
   ) u_refresh (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .tick_o    (refresh_tick)
   );

   // only the hysteresis register is writable; result offsets drop writes
   assign hys_wr_hit = reg_wr_i && (reg_addr_i == light_readout_pkg::OFS_DARK_EXIT_HYS);

   // hysteresis code kept as written; each step is a fixed current increment
   // shared with the threshold code, so the two add with no scaling here
   // limitation: no write protection, a host may change it at any time
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         dark_exit_hysteresis_ff <= light_readout_pkg::RST_DARK_EXIT_HYS;
      end else if (hys_wr_hit) begin
         dark_exit_hysteresis_ff <= reg_wdata_i;
      end
   end

   // whole 13-bit value captured at once, so both bytes always match;
   // a disabled sensor keeps its last result instead of clearing it
   // hazard: the converter must hold its word steady around the tick
   genvar g;
   generate
      for (g = 0; g < light_readout_pkg::NUM_SENSORS; g++) begin : g_result
         assign capture_en[g] = refresh_tick && sensor_en_i[g];

         always_ff @(posedge clk_sys_i) begin
            if (!rst_n_i) begin
               result_ff[g] <= light_readout_pkg::RST_RESULT;
            end else if (capture_en[g]) begin
               result_ff[g] <= conv_value[g];
            end
         end

         // low byte bits 7..0, high byte bits 12..8 under a zero reserved top
         assign level_low[g]  = result_ff[g][7:0];
         assign level_high[g] = {3'h0, result_ff[g][12:8]};
      end
   endgenerate

   // register map, one byte per offset:
   //   0x20 hysteresis code, read and write
   //   0x21 sensor one low byte, read only
   //   0x22 sensor one high byte, read only
   //   0x23 sensor two low byte, read only
   //   0x24 sensor two high byte, read only
   // any other offset reads zero and drops writes
   always_comb begin
      nxt_rdata = 8'h00;
      case (reg_addr_i)
         light_readout_pkg::OFS_DARK_EXIT_HYS: begin
            nxt_rdata = dark_exit_hysteresis_ff;
         end
         light_readout_pkg::OFS_S1_LEVEL_LOW: begin
            nxt_rdata = level_low[0];
         end
         light_readout_pkg::OFS_S1_LEVEL_HIGH: begin
            nxt_rdata = level_high[0];
         end
         light_readout_pkg::OFS_S2_LEVEL_LOW: begin
            nxt_rdata = level_low[1];
         end
         light_readout_pkg::OFS_S2_LEVEL_HIGH: begin
            nxt_rdata = level_high[1];
         end
         default: begin
            nxt_rdata = 8'h00;
         end
      endcase
   end

   // read data registered, holds until the next read strobe
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         reg_rdata_o <= nxt_rdata;
      end
   end

   // exit point is threshold plus hysteresis, widened so no wrap
   assign exit_level = {1'b0, dark_entry_threshold_i} + {1'b0, dark_exit_hysteresis_ff};

   // band edges; inside the band the comparator holds its last decision,
   // which keeps the backlight from hunting on a slowly drifting input
   assign above_exit  = {1'b0, sensor_level_i} > exit_level;
   assign below_entry = sensor_level_i < dark_entry_threshold_i;

   // dark comparator with hysteresis band between entry and exit;
   // disabling it forgets the dark state, so a later enable starts on the
   // bright side until the input is seen below the threshold again
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         dark_ff <= 1'b0;
      end else if (!dark_cmp_en_i) begin
         dark_ff <= 1'b0;
      end else if (above_exit) begin
         dark_ff <= 1'b0;
      end else if (below_entry) begin
         dark_ff <= 1'b1;
      end
   end

   // level choice, first match wins:
   //   dark comparator on and tripped      -> dark
   //   dark comparator on, office one off  -> office
   //   office comparator on and requesting -> office
   //   anything else                       -> daylight
   // the office input is already a decision; its threshold lives outside
   always_comb begin
      if (dark_cmp_en_i && dark_ff) begin
         nxt_level = light_readout_pkg::LEVEL_DARK;
      end else if (dark_cmp_en_i && !office_cmp_en_i) begin
         nxt_level = light_readout_pkg::LEVEL_OFFICE;
      end else if (office_cmp_en_i && office_request_i) begin
         nxt_level = light_readout_pkg::LEVEL_OFFICE;
      end else begin
         nxt_level = light_readout_pkg::LEVEL_DAYLIGHT;
      end
   end

   // backlight level registered, so it changes only on a clock edge
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         backlight_level_o <= light_readout_pkg::LEVEL_DAYLIGHT;
      end else begin
         backlight_level_o <= nxt_level;
      end
   end

   // trip flag mirrors the comparator, in step with the level above
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         dark_trip_o <= 1'b0;
      end else begin
         dark_trip_o <= dark_ff;
      end
   end
endmodule

/* File: pkg/light_readout_pkg.sv */
// Purpose: constants and carrier types for the ambient light level readout
// Assumes: 200 MHz system clock, byte-wide register port
// Notes:   every offset, field position and timing count lives here
// How it works
// - above threshold plus hysteresis, dark exits to office; the code exits to daylight if the office comparator is on and not requesting
// - hysteresis code is linear, 0.54 uA per step
// - 0x21 returns sensor one result bits 7..0
// - high byte holds bits 12..8, top three reserved
// - sensor two result at 0x23 and 0x24
// - enabled sensor result refreshed every 80 ms
// - result registers read-only, writes ignored
// - below dark threshold, backlight enters dark level
// - dark comparator wins over office comparator
package light_readout_pkg;
   localparam int          ADDR_W             = 8;
   localparam int          DATA_W             = 8;
   localparam int          RESULT_W           = 13;
   localparam int          HIGH_W             = RESULT_W - DATA_W;
   localparam int          NUM_SENSORS        = 2;
   // register offsets
   localparam logic [7:0]  OFS_DARK_EXIT_HYS  = 8'h20;
   localparam logic [7:0]  OFS_S1_LEVEL_LOW   = 8'h21;
   localparam logic [7:0]  OFS_S1_LEVEL_HIGH  = 8'h22;
   localparam logic [7:0]  OFS_S2_LEVEL_LOW   = 8'h23;
   localparam logic [7:0]  OFS_S2_LEVEL_HIGH  = 8'h24;
   localparam logic [7:0]  RST_DARK_EXIT_HYS  = 8'h00;
   localparam logic [12:0] RST_RESULT         = 13'h0000;
   // hysteresis scale, nanoamps per code step (0.54 uA)
   localparam int          HYS_STEP_NA        = 540;
   // refresh timing
   localparam int          CLK_PERIOD_PS      = 5000;
   localparam int          REFRESH_MS         = 80;
   localparam longint      REFRESH_CYCLES     =
      (longint'(REFRESH_MS) * 64'd1000000000) / longint'(CLK_PERIOD_PS);

   typedef enum logic [1:0] {
      LEVEL_DAYLIGHT,
      LEVEL_OFFICE,
      LEVEL_DARK
   } backlight_level_t;

   typedef struct packed {
      logic              valid;
      logic [RESULT_W-1:0] value;
   } conversion_t;
endpackage

/* File: rtl/refresh_tick.sv */
// Purpose: divider giving a one-cycle refresh enable
// Assumes: synchronous active-low reset
// Notes:   period is a parameter so simulation can shorten it
`timescale 1ns/10ps
module refresh_tick #(
   parameter int unsigned PERIOD = 16000000
) (
   input  wire logic clk_sys_i,
   input  wire logic rst_n_i,
   output logic      tick_o
);
   logic [31:0] count_ff;

   // count up, pulse on wrap
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         count_ff <= 32'h00000000;
         tick_o   <= 1'b0;
      end else if (count_ff == 32'(PERIOD - 1)) begin
         count_ff <= 32'h00000000;
         tick_o   <= 1'b1;
      end else begin
         count_ff <= count_ff + 32'h00000001;
         tick_o   <= 1'b0;
      end
   end
endmodule

/* File: bench/light_host_model.sv */
// Purpose: host side of the register port
// Assumes: strobes change on the falling edge
// Notes:   idle must follow the last transfer
`timescale 1ns/10ps
module light_host_model (
   input  wire logic clk_sys_i,
   output logic      wr_o,
   output logic      rd_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o
);
   initial {wr_o, rd_o, addr_o, wdata_o} = 18'h00000;
   // strobes held across back-to-back calls, so no double assignment
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      {wr_o, rd_o, addr_o, wdata_o} = {w, !w, a, d};
      @(negedge clk_sys_i);
   endtask
   task automatic idle();
      {wr_o, rd_o} = 2'h0;
      @(negedge clk_sys_i);
   endtask
endmodule

/* File: bench/light_level_readout_props.sv */
// Purpose: port checks for the light readout block
// Assumes: one clock, synchronous active-low reset
// Notes:   result contents are judged by the bench
`timescale 1ns/10ps
module light_level_readout_props (
   input wire logic       clk_sys_i,
   input wire logic       rst_n_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [7:0] sensor_level_i,
   input wire logic [7:0] dark_entry_threshold_i,
   input wire logic       dark_cmp_en_i,
   input wire logic       office_cmp_en_i,
   input wire light_readout_pkg::backlight_level_t backlight_level_o,
   input wire logic       dark_trip_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   // write then read of the hysteresis byte
   sequence hys_wr_rd;
      reg_wr_i && reg_addr_i == 8'h20 ##1 reg_rd_i && !reg_wr_i && reg_addr_i == 8'h20;
   endsequence
   AST_HYS_RDBACK: assert property (hys_wr_rd |=> reg_rdata_o == $past(reg_wdata_i, 2))
      else $error("hysteresis readback wrong");
   AST_RESV_ZERO: assert property (reg_rd_i && (reg_addr_i == 8'h22 || reg_addr_i == 8'h24)
      |=> reg_rdata_o[7:5] == 3'h0) else $error("reserved bits set");
   AST_UNMAPPED: assert property (reg_rd_i && reg_addr_i > 8'h24 |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   AST_RD_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved");
   // input below threshold while the dark comparator is on
   sequence dark_entry_seen;
      dark_cmp_en_i && sensor_level_i < dark_entry_threshold_i;
   endsequence
   AST_DARK_SET: assert property (dark_entry_seen |-> ##2 dark_trip_o)
      else $error("dark not tripped");
   AST_DARK_OFF: assert property (!dark_cmp_en_i |-> ##2 !dark_trip_o)
      else $error("trip without enable");
   AST_LEVEL_DARK: assert property (dark_trip_o && $past(dark_cmp_en_i)
      |-> backlight_level_o == light_readout_pkg::LEVEL_DARK) else $error("not dark");
   AST_DARK_EXIT: assert property ($fell(dark_trip_o) && $past(dark_cmp_en_i)
      && !$past(office_cmp_en_i) |-> backlight_level_o == light_readout_pkg::LEVEL_OFFICE)
      else $error("no office");
endmodule
bind light_level_readout light_level_readout_props light_level_readout_props_inst (.*);

/* File: bench/light_level_readout_tb.sv */
// Purpose: directed bench for the light readout block
// Assumes: refresh period shortened to 20 cycles
// Notes:   inputs move on the falling edge only
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
   $display("wrong value at %0t: %h not %h", $time, a, e); end end
module light_level_readout_tb;
   logic clk_sys_i = 0, rst_n_i = 0, wr, rd, trip, dark_en = 0, off_en = 0, off_req = 0;
   logic [7:0] addr, wdata, rdata, lvl = 8'h80, thr = 8'h40;
   logic [1:0] en = 2'h0;
   light_readout_pkg::conversion_t c1 = '0, c2 = '0;
   light_readout_pkg::backlight_level_t bl;
   int fail_count = 0, n_checks = 0, cyc = 0;
   light_host_model light_host_model_inst (.clk_sys_i(clk_sys_i), .wr_o(wr), .rd_o(rd),
      .addr_o(addr), .wdata_o(wdata));
   light_level_readout #(.REFRESH_PERIOD(20)) light_level_readout_inst (.clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .sensor_en_i(en), .sensor_one_conv_i(c1), .sensor_two_conv_i(c2),
      .sensor_level_i(lvl), .dark_entry_threshold_i(thr), .dark_cmp_en_i(dark_en),
      .office_cmp_en_i(off_en), .office_request_i(off_req), .backlight_level_o(bl),
      .dark_trip_o(trip));
   initial forever #2.5 clk_sys_i = !clk_sys_i;
   // hang guard, the whole run needs well under 1000 cycles
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc > 3000) begin
         fail_count++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      light_host_model_inst.xfer(1'b0, a, 8'h00);
      `CHK(rdata, e)
      light_host_model_inst.idle();
   endtask
   task automatic t_hys();
      light_host_model_inst.xfer(1'b1, 8'h20, 8'hFF);
      light_host_model_inst.xfer(1'b0, 8'h20, 8'h00);
      `CHK(rdata, 8'hFF)
      light_host_model_inst.idle();
   endtask
   task automatic t_results();
      c1.value = 13'h1ABC;
      c2.value = 13'h0567;
      en = 2'h3;
      repeat (25) @(negedge clk_sys_i);
      rd_chk(8'h21, 8'hBC);
      rd_chk(8'h22, 8'h1A);
      rd_chk(8'h23, 8'h67);
      rd_chk(8'h24, 8'h05);
   endtask
   task automatic t_read_only();
      for (int a = 8'h21; a < 8'h25; a++) light_host_model_inst.xfer(1'b1, 8'(a), 8'hFF);
      light_host_model_inst.idle();
      rd_chk(8'h21, 8'hBC);
      rd_chk(8'h24, 8'h05);
      rd_chk(8'h30, 8'h00);
   endtask
   task automatic t_refresh();
      en = 2'h1;
      c1.value = 13'h0F0F;
      c2.value = 13'h1FFF;
      repeat (25) @(negedge clk_sys_i);
      rd_chk(8'h22, 8'h0F);
      rd_chk(8'h21, 8'h0F);
      rd_chk(8'h23, 8'h67);
   endtask
   task automatic t_compare();
      light_host_model_inst.xfer(1'b1, 8'h20, 8'h10);
      light_host_model_inst.idle();
      {lvl, dark_en, off_en, off_req} = {8'h30, 3'h7};
      repeat (3) @(negedge clk_sys_i);
      `CHK(trip, 1'b1)
      `CHK(bl, light_readout_pkg::LEVEL_DARK)
      lvl = 8'h50; // equal to threshold plus hysteresis, not above it
      repeat (3) @(negedge clk_sys_i);
      `CHK(trip, 1'b1)
      {lvl, off_en} = {8'h51, 1'b0};
      repeat (3) @(negedge clk_sys_i);
      `CHK(trip, 1'b0)
      `CHK(bl, light_readout_pkg::LEVEL_OFFICE)
      {lvl, off_en, off_req} = {8'h60, 2'h3};
      repeat (3) @(negedge clk_sys_i);
      `CHK(bl, light_readout_pkg::LEVEL_OFFICE)
      off_req = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      `CHK(bl, light_readout_pkg::LEVEL_DAYLIGHT)
   endtask
   initial begin
      repeat (3) @(negedge clk_sys_i);
      rst_n_i = 1;
      `CHK(trip, 1'b0)
      `CHK(bl, light_readout_pkg::LEVEL_DAYLIGHT)
      for (int a = 8'h20; a < 8'h25; a++) rd_chk(8'(a), 8'h00);
      t_hys();
      t_results();
      t_read_only();
      t_refresh();
      t_compare();
      print_verdict();
   end
endmodule
